// >>> core/dbf_brake.sv
// dc braking sequencer and brake / frequency signal output with avalon-mm registers
`timescale 1ns/10ps
`default_nettype none
`include "dbf_params.svh"

module dbf_brake #(
    parameter int TENTH_S_CYCLES = (`DBF_CLK_HZ / 1000) * `DBF_TENTH_S_MS,
    parameter int DELAY_CYCLES   = (`DBF_CLK_HZ / 1000) * `DBF_DELAY_MS
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic [11:0] actualFreq,
    input  wire logic        motorRun,
    input  wire logic        stopRequest,
    input  wire logic [11:0] potReference,
    output logic      [11:0] referenceFreq,
    output logic             driveOff,
    output logic             dcPulse,
    output logic             dcActive,
    output logic             brakeOut
);
    // the turn-on delay needs at least two cycles to be seen as a delay
    if (TENTH_S_CYCLES < 1 || DELAY_CYCLES < 2) begin : g_bad_counts
        $error("dbf_brake: cycle counts out of range");
    end

    // registers
    logic [1:0]  enableCode, next_enableCode;
    logic [1:0]  srcCode, next_srcCode;
    logic [1:0]  refCode, next_refCode;
    logic [11:0] startFreq, next_startFreq;
    logic [11:0] waitTime, next_waitTime;
    logic [11:0] torque, next_torque;
    logic [11:0] duration, next_duration;
    logic [11:0] accelThr, next_accelThr;
    logic [11:0] decelThr, next_decelThr;
    logic [11:0] digRef, next_digRef;
    logic        ack, next_ack;
    logic [31:0] next_readdata;
    logic [11:0] wVal;

    function automatic logic [11:0] clampv(input logic [11:0] v, input logic [11:0] lo,
                                            input logic [11:0] hi);
        clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clampv

    // one wait state on every access; writes land and reads end at the second edge
    assign waitrequest = (read | write) & ~ack;

    dbf_pkg::dbf_state_t state, next_state;
    localparam dbf_pkg::dbf_state_t DBF_IDLE  = dbf_pkg::DBF_IDLE;
    localparam dbf_pkg::dbf_state_t DBF_COAST = dbf_pkg::DBF_COAST;
    localparam dbf_pkg::dbf_state_t DBF_BRAKE = dbf_pkg::DBF_BRAKE;
    logic        brakeDone, next_brakeDone;
    logic [31:0] tickCnt, next_tickCnt;
    logic [11:0] tenths, next_tenths;
    logic [7:0]  pwmCnt, next_pwmCnt;
    logic        sigRaw, next_sigRaw;
    logic [31:0] dlyCnt, next_dlyCnt;
    logic        sigOut, next_sigOut;

    always_comb begin
        wVal = writedata[11:0];
        next_enableCode = enableCode;
        next_srcCode = srcCode;
        next_refCode = refCode;
        next_startFreq = startFreq;
        next_waitTime = waitTime;
        next_torque = torque;
        next_duration = duration;
        next_accelThr = accelThr;
        next_decelThr = decelThr;
        next_digRef = digRef;
        next_readdata = readdata;
        next_ack = (read | write) & ~ack;
        if (write && ack) begin
            case (address)
                `DBF_REG_CTRL: begin
                    if (writedata[`DBF_CTRL_EN_LSB +: 2] <= `DBF_EN_ON)
                        next_enableCode = writedata[`DBF_CTRL_EN_LSB +: 2];
                    if (writedata[`DBF_CTRL_SRC_LSB +: 2] == `DBF_SRC_RUN ||
                        writedata[`DBF_CTRL_SRC_LSB +: 2] == `DBF_SRC_FREQ)
                        next_srcCode = writedata[`DBF_CTRL_SRC_LSB +: 2];
                    next_refCode = writedata[`DBF_CTRL_REF_LSB +: 2];
                end
                `DBF_REG_START:  next_startFreq = clampv(wVal, `DBF_START_MIN, `DBF_START_MAX);
                `DBF_REG_WAIT:   next_waitTime = clampv(wVal, 12'h000, `DBF_WAIT_MAX);
                `DBF_REG_TORQUE: next_torque = clampv(wVal, 12'h000, `DBF_TORQUE_MAX);
                `DBF_REG_DUR:    next_duration = clampv(wVal, 12'h000, `DBF_DUR_MAX);
                `DBF_REG_ACCEL:  next_accelThr = clampv(wVal, 12'h000, `DBF_FREQ_MAX);
                `DBF_REG_DECEL:  next_decelThr = clampv(wVal, 12'h000, `DBF_FREQ_MAX);
                `DBF_REG_DIGREF: next_digRef = clampv(wVal, `DBF_DIGREF_MIN, `DBF_FREQ_MAX);
                default: ;
            endcase
        end
        if (read && !ack) begin
            case (address)
                `DBF_REG_CTRL:   next_readdata = {22'h0, refCode, 2'h0, srcCode, 2'h0, enableCode};
                `DBF_REG_START:  next_readdata = {20'h0, startFreq};
                `DBF_REG_WAIT:   next_readdata = {20'h0, waitTime};
                `DBF_REG_TORQUE: next_readdata = {20'h0, torque};
                `DBF_REG_DUR:    next_readdata = {20'h0, duration};
                `DBF_REG_ACCEL:  next_readdata = {20'h0, accelThr};
                `DBF_REG_DECEL:  next_readdata = {20'h0, decelThr};
                `DBF_REG_DIGREF: next_readdata = {20'h0, digRef};
                `DBF_REG_FREQ:   next_readdata = {20'h0, actualFreq};
                `DBF_REG_STATUS: next_readdata = {26'h0, state, dcActive, driveOff, sigOut,
                                                  brakeOut};
                default:         next_readdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            enableCode <= `DBF_EN_OFF;
            srcCode    <= `DBF_SRC_RUN;
            refCode    <= `DBF_REF_POT;
            startFreq  <= `DBF_START_RST;
            waitTime   <= 12'h000;
            torque     <= 12'h000;
            duration   <= 12'h000;
            accelThr   <= 12'h000;
            decelThr   <= 12'h000;
            digRef     <= `DBF_DIGREF_MIN;
            ack        <= 1'b0;
            readdata   <= 32'h0;
        end else begin
            enableCode <= next_enableCode;
            srcCode    <= next_srcCode;
            refCode    <= next_refCode;
            startFreq  <= next_startFreq;
            waitTime   <= next_waitTime;
            torque     <= next_torque;
            duration   <= next_duration;
            accelThr   <= next_accelThr;
            decelThr   <= next_decelThr;
            digRef     <= next_digRef;
            ack        <= next_ack;
            readdata   <= next_readdata;
        end
    end

    // stage-zero reference: digital value in mode 02 or in frequency-signal mode, else potentiometer
    logic        digitalRef;
    logic [11:0] next_referenceFreq;
    assign digitalRef = (refCode == `DBF_REF_DIG);
    // in frequency-signal mode the stage-zero source is forced digital
    always_comb begin
        next_referenceFreq = (digitalRef || srcCode == `DBF_SRC_FREQ) ? digRef
                                                                      : potReference;
    end

    // braking sequencer
    logic tenthTick;
    assign tenthTick = (tickCnt == 32'(TENTH_S_CYCLES - 1));

    always_comb begin
        next_state = state;
        next_brakeDone = brakeDone;
        next_tickCnt = tenthTick ? 32'h0 : tickCnt + 32'h1;
        next_tenths = tenthTick ? tenths + 12'h001 : tenths;
        case (state)
            DBF_IDLE: begin
                next_tickCnt = 32'h0;
                next_tenths = 12'h000;
                if (enableCode == `DBF_EN_ON && stopRequest && !brakeDone &&
                    actualFreq < startFreq)
                    next_state = DBF_COAST;
            end
            DBF_COAST: begin
                // compare the count after this edge so the phase lasts exactly its time
                if (next_tenths >= waitTime) begin
                    if (duration == 12'h000) begin
                        next_state = DBF_IDLE;
                        next_brakeDone = 1'b1;
                    end else begin
                        next_state = DBF_BRAKE;
                    end
                    next_tickCnt = 32'h0;
                    next_tenths = 12'h000;
                end
            end
            DBF_BRAKE: begin
                if (next_tenths >= duration) begin
                    next_state = DBF_IDLE;
                    next_brakeDone = 1'b1;
                end
            end
            default: next_state = DBF_IDLE;
        endcase
        // a finished sequence stays idle until the stop request is withdrawn
        if (!stopRequest) begin
            next_state = DBF_IDLE;
            next_brakeDone = 1'b0;
        end
    end

    // dc pulse width proportional to torque percentage
    always_comb begin
        next_pwmCnt = (pwmCnt == `DBF_PWM_PERIOD - 8'h01) ? 8'h00 : pwmCnt + 8'h01;
    end

    // frequency threshold with hysteresis and turn-on delay
    logic [12:0] onLevel, offLevel;
    assign onLevel  = (accelThr > `DBF_HYST_ON) ? {1'b0, accelThr - `DBF_HYST_ON} : 13'h0000;
    assign offLevel = {1'b0, decelThr} - {1'b0, `DBF_HYST_OFF};
    always_comb begin
        next_sigRaw = sigRaw;
        if (!sigRaw && {1'b0, actualFreq} >= onLevel && actualFreq != 12'h000)
            next_sigRaw = 1'b1;
        else if (sigRaw && ($signed(offLevel) > $signed({1'b0, actualFreq})))
            next_sigRaw = 1'b0;
        next_dlyCnt = (sigRaw && !sigOut) ? dlyCnt + 32'h1 : 32'h0;
        next_sigOut = sigRaw && (sigOut || dlyCnt == 32'(DELAY_CYCLES - 1));
    end

    dbf_pkg::dbf_stage_t stage;
    always_comb begin
        stage.driveOff = (state != DBF_IDLE);
        stage.dcActive = (state == DBF_BRAKE);
        stage.dcPulse  = (state == DBF_BRAKE) && ({4'h0, pwmCnt} < torque);
        // brake released (high) while driven above 0 Hz in run mode; in frequency-signal mode it follows the delayed threshold signal
        stage.brakeOut = (srcCode == `DBF_SRC_FREQ) ? sigOut
                                                    : (motorRun && actualFreq != 12'h000);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state         <= DBF_IDLE;
            brakeDone     <= 1'b0;
            tickCnt       <= 32'h0;
            tenths        <= 12'h000;
            pwmCnt        <= 8'h00;
            sigRaw        <= 1'b0;
            dlyCnt        <= 32'h0;
            sigOut        <= 1'b0;
            referenceFreq <= 12'h000;
            driveOff      <= 1'b0;
            dcPulse       <= 1'b0;
            dcActive      <= 1'b0;
            brakeOut      <= 1'b0;
        end else begin
            state         <= next_state;
            brakeDone     <= next_brakeDone;
            tickCnt       <= next_tickCnt;
            tenths        <= next_tenths;
            pwmCnt        <= next_pwmCnt;
            sigRaw        <= next_sigRaw;
            dlyCnt        <= next_dlyCnt;
            sigOut        <= next_sigOut;
            referenceFreq <= next_referenceFreq;
            driveOff      <= stage.driveOff;
            dcPulse       <= stage.dcPulse;
            dcActive      <= stage.dcActive;
            brakeOut      <= stage.brakeOut;
        end
    end

    sequence s_brakeEntry;
        state == DBF_COAST ##1 state == DBF_BRAKE;
    endsequence

    chk_enable_gates_entry: assert property (@(posedge clk) disable iff (reset)
        (state == DBF_IDLE && enableCode == `DBF_EN_OFF) |=> state == DBF_IDLE)
        else $error("braking started while disabled");
    chk_start_below_thr: assert property (@(posedge clk) disable iff (reset)
        (state == DBF_IDLE && next_state == DBF_COAST) |-> actualFreq < startFreq)
        else $error("braking began above start frequency");
    chk_coast_no_dc: assert property (@(posedge clk) disable iff (reset)
        state == DBF_COAST |=> !dcActive && !dcPulse && driveOff)
        else $error("dc applied while coasting");
    chk_pulse_torque: assert property (@(posedge clk) disable iff (reset)
        torque == 12'h000 |=> !dcPulse)
        else $error("pulse with zero torque");
    chk_brake_ends: assert property (@(posedge clk) disable iff (reset)
        (state == DBF_BRAKE && stopRequest && next_tenths < duration) |=> state == DBF_BRAKE)
        else $error("braking ended before its duration");
    chk_brake_start: assert property (@(posedge clk) disable iff (reset)
        s_brakeEntry |-> tenths == 12'h000 && tickCnt == 32'h0)
        else $error("brake timing did not start from zero");
    chk_dc_only_brake: assert property (@(posedge clk) disable iff (reset)
        dcPulse |-> $past(state) == DBF_BRAKE)
        else $error("dc pulse outside braking");
    chk_run_mode_brake: assert property (@(posedge clk) disable iff (reset)
        (srcCode == `DBF_SRC_RUN && motorRun && actualFreq != 12'h000) |=> brakeOut)
        else $error("brake engaged while driven");
    chk_sig_delay: assert property (@(posedge clk) disable iff (reset)
        $rose(sigOut) |-> $past(sigRaw, 2))
        else $error("frequency signal not delayed");
    chk_idle_after: assert property (@(posedge clk) disable iff (reset)
        (state == DBF_BRAKE && next_tenths >= duration) |=> state == DBF_IDLE)
        else $error("sequencer did not return idle");
    chk_done_holds_idle: assert property (@(posedge clk) disable iff (reset)
        (state == DBF_IDLE && brakeDone) |=> state == DBF_IDLE)
        else $error("braking restarted without a new stop request");
endmodule : dbf_brake
`default_nettype wire

// >>> core/dbf_params.svh
// register offsets, field positions, reset values and timing counts of the brake block
`ifndef DBF_PARAMS_SVH
`define DBF_PARAMS_SVH

`define DBF_CLK_HZ          50000000
`define DBF_TICK_NS         20
// frequencies are in units of 0.1 Hz, times in units of 0.1 s
`define DBF_REG_CTRL        8'h00
`define DBF_REG_START       8'h04
`define DBF_REG_WAIT        8'h08
`define DBF_REG_TORQUE      8'h0C
`define DBF_REG_DUR         8'h10
`define DBF_REG_ACCEL       8'h14
`define DBF_REG_DECEL       8'h18
`define DBF_REG_DIGREF      8'h1C
`define DBF_REG_FREQ        8'h20
`define DBF_REG_STATUS      8'h24
`define DBF_CTRL_EN_LSB     0
`define DBF_CTRL_SRC_LSB    4
`define DBF_CTRL_REF_LSB    8
`define DBF_EN_OFF          2'h0
`define DBF_EN_ON           2'h1
`define DBF_SRC_RUN         2'h0
`define DBF_SRC_FREQ        2'h2
`define DBF_REF_POT         2'h1
`define DBF_REF_DIG         2'h2
`define DBF_START_RST       12'h005
`define DBF_START_MIN       12'h005
`define DBF_START_MAX       12'h064
`define DBF_WAIT_MAX        12'h032
`define DBF_TORQUE_MAX      12'h064
`define DBF_DUR_MAX         12'h258
`define DBF_FREQ_MAX        12'hE10
`define DBF_DIGREF_MIN      12'h005
`define DBF_HYST_ON         12'h005
`define DBF_HYST_OFF        12'h00F
`define DBF_DELAY_MS        60
`define DBF_TENTH_S_MS      100
`define DBF_PWM_PERIOD      8'h64

`endif

// >>> core/dbf_pkg.sv
// types shared by the brake and frequency-signal block
package dbf_pkg;
    typedef enum logic [1:0] {
        DBF_IDLE  = 2'b00,
        DBF_COAST = 2'b01,
        DBF_BRAKE = 2'b10
    } dbf_state_t;

    typedef struct packed {
        logic        dcActive;
        logic        dcPulse;
        logic        driveOff;
        logic        brakeOut;
    } dbf_stage_t;
endpackage : dbf_pkg

// >>> test/dbf_power_stage.sv
// power stage model: output frequency follows the command, decays while the drive is off
`timescale 1ns/10ps
`default_nettype none
module dbf_power_stage (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [11:0] targetFreq,
    input  wire logic        runCmd,
    input  wire logic        driveOff,
    input  wire logic        dcActive,
    output logic      [11:0] actualFreq,
    output logic             motorRun
);
    // an undriven rotor slows down one step each cycle, never jumps
    always_ff @(posedge clk) begin
        if (reset) begin
            actualFreq <= 12'h000;
        end else if (driveOff || dcActive) begin
            actualFreq <= (actualFreq != 12'h000) ? actualFreq - 12'h001 : 12'h000;
        end else begin
            actualFreq <= targetFreq;
        end
    end
    assign motorRun = runCmd && !driveOff;
endmodule : dbf_power_stage
`default_nettype wire

// >>> test/dc_brake_and_freq_signal_tb_top.sv
// self-checking bench for the dc brake and frequency signal block
`timescale 1ns/10ps
`default_nettype none
`include "dbf_params.svh"
module dc_brake_and_freq_signal_tb_top;
    localparam int TENTH = 100;
    localparam int DELAY = 20;
    logic        clk, reset, read, write, waitrequest, motorRun, stopRequest, runCmd;
    logic        driveOff, dcPulse, dcActive, brakeOut;
    logic [7:0]  address;
    logic [31:0] writedata, readdata, rngState, rdVal;
    logic [11:0] actualFreq, potReference, referenceFreq, targetFreq;
    int          failures, comparisons, n, p, torque, accel, decel;

    dbf_brake #(.TENTH_S_CYCLES(TENTH), .DELAY_CYCLES(DELAY)) dbf_brake_inst (
        .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .actualFreq(actualFreq), .motorRun(motorRun), .stopRequest(stopRequest),
        .potReference(potReference), .referenceFreq(referenceFreq), .driveOff(driveOff),
        .dcPulse(dcPulse), .dcActive(dcActive), .brakeOut(brakeOut));

    dbf_power_stage dbf_power_stage_inst (
        .clk(clk), .reset(reset), .targetFreq(targetFreq), .runCmd(runCmd),
        .driveOff(driveOff), .dcActive(dcActive), .actualFreq(actualFreq),
        .motorRun(motorRun));

    function automatic logic [31:0] nextRand();
        rngState = rngState ^ (rngState << 13);
        rngState = rngState ^ (rngState >> 17);
        rngState = rngState ^ (rngState << 5);
        return rngState;
    endfunction : nextRand

    function automatic int expPulses(input int pct, input int tenths);
        return pct * tenths * TENTH / 100;
    endfunction : expPulses

    // one avalon access; held until the edge waitrequest is sampled low, data taken there
    task automatic busAccess(input logic isWrite, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        address   <= a;
        writedata <= d;
        write     <= isWrite;
        read      <= !isWrite;
        @(posedge clk);
        while (waitrequest !== 1'b0 && t < 50) begin
            @(posedge clk);
            t++;
        end
        if (t >= 50) begin
            failures++;
        end
        rdVal = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask : busAccess

    task automatic checkEq(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : checkEq

    task automatic checkNear(input string what, input int exp, input int got, input int tol);
        comparisons++;
        if (got < exp - tol || got > exp + tol) begin
            failures++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : checkNear

    task automatic results();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        results();
    end

    initial begin
        rngState = 32'h0000880B;
        {reset, read, write, stopRequest, runCmd} = 5'h10;
        {address, writedata, targetFreq, failures, comparisons} = '0;
        potReference = 12'(nextRand());
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        busAccess(1'b0, `DBF_REG_CTRL, 32'h0);
        checkEq("ctrl reset", 32'h00000100, rdVal);
        busAccess(1'b0, `DBF_REG_START, 32'h0);
        checkEq("start reset", {20'h0, `DBF_START_RST}, rdVal);
        busAccess(1'b0, 8'h40, 32'h0);
        checkEq("unmapped read", 32'h0, rdVal);
        checkEq("pot reference", {20'h0, potReference}, {20'h0, referenceFreq});
        busAccess(1'b1, `DBF_REG_ACCEL, 32'h00000FFF);
        busAccess(1'b0, `DBF_REG_ACCEL, 32'h0);
        checkEq("accel clamp", {20'h0, `DBF_FREQ_MAX}, rdVal);
        busAccess(1'b1, `DBF_REG_START, 32'h00000032);
        // disabled: falling below start must not stop the drive
        runCmd      <= 1'b1;
        targetFreq  <= 12'h0C8;
        stopRequest <= 1'b1;
        repeat (5) @(posedge clk);
        targetFreq <= 12'h028;
        repeat (50) @(posedge clk);
        checkEq("drive off when disabled", 32'h0, {31'h0, driveOff});
        stopRequest <= 1'b0;
        targetFreq  <= 12'h0C8;
        $display("test disabled done");
        torque = nextRand() % 101;
        busAccess(1'b1, `DBF_REG_CTRL, 32'h00000101);
        busAccess(1'b1, `DBF_REG_WAIT, 32'h00000003);
        busAccess(1'b1, `DBF_REG_TORQUE, 32'(torque));
        busAccess(1'b1, `DBF_REG_DUR, 32'h00000002);
        stopRequest <= 1'b1;
        repeat (5) @(posedge clk);
        targetFreq <= 12'h028;
        n = 0;
        while (driveOff !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        checkEq("coast entered", 32'h1, {31'h0, driveOff});
        n = 0;
        while (dcActive !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        checkNear("coast cycles", 3 * TENTH, n, 2);
        n = 0;
        p = 0;
        while (dcActive === 1'b1 && n < 1000) begin
            p += int'(dcPulse === 1'b1);
            @(negedge clk);
            n++;
        end
        checkEq("dc cycles", 32'(2 * TENTH), 32'(n));
        checkNear("dc pulses", expPulses(torque, 2), p, 4);
        busAccess(1'b0, `DBF_REG_STATUS, 32'h0);
        checkEq("state after brake", {30'h0, dbf_pkg::DBF_IDLE}, {30'h0, rdVal[5:4]});
        checkEq("dc after brake", 32'h0, {31'h0, rdVal[3]});
        stopRequest <= 1'b0;
        targetFreq  <= 12'h064;
        repeat (10) @(posedge clk);
        checkEq("brake released running", 32'h1, {31'h0, brakeOut});
        targetFreq <= 12'h000;
        repeat (10) @(posedge clk);
        checkEq("brake held at zero", 32'h0, {31'h0, brakeOut});
        $display("test braking done");
        busAccess(1'b1, `DBF_REG_DIGREF, 32'h0000012C);
        busAccess(1'b1, `DBF_REG_CTRL, 32'h00000221);
        repeat (2) @(posedge clk);
        checkEq("stage zero reference", 32'h0000012C, {20'h0, referenceFreq});
        for (int k = 0; k < 2; k++) begin
            accel = 400 + nextRand() % 3000;
            decel = (k == 1) ? accel + 5 : accel - 300;
            busAccess(1'b1, `DBF_REG_ACCEL, 32'(accel));
            busAccess(1'b1, `DBF_REG_DECEL, 32'(decel));
            targetFreq <= 12'(accel - 6);
            repeat (DELAY + 10) @(posedge clk);
            checkEq("signal below accel", 32'h0, {31'h0, brakeOut});
            targetFreq <= 12'(accel - 5);
            n = 0;
            while (brakeOut !== 1'b1 && n < 200) begin
                @(negedge clk);
                n++;
            end
            // stage, threshold and output registers plus the counting edge add four
            checkNear("signal delay", DELAY + 4, n, 3);
            @(posedge clk);
            targetFreq <= 12'(decel - 15);
            repeat (10) @(posedge clk);
            checkEq("signal at decel", 32'h1, {31'h0, brakeOut});
            targetFreq <= 12'(decel - 16);
            repeat (5) @(posedge clk);
            checkEq("signal past decel", 32'h0, {31'h0, brakeOut});
        end
        $display("test frequency signal done");
        results();
    end
endmodule : dc_brake_and_freq_signal_tb_top
`default_nettype wire
